// ### ods_sync_ctrl.sv
// Output divider alignment, output enables and polarity for all channels
`timescale 1ns/1ps
`default_nettype none
module ods_sync_ctrl #(
  parameter int unsigned NCH = ods_pkg::NUM_CH
) (
  input  wire logic                              clock_i,
  input  wire logic                              rst_i,
  input  wire logic                              chip_reset_n_i,
  input  wire logic                              sync_n_i,
  input  wire logic                              chip_sleep_n_i,
  input  wire logic                              vco_cal_busy_i,
  input  wire logic                              vco_div_used_i,
  input  wire logic                              soft_sync_stage_i,
  input  wire logic                              update_regs_i,
  input  wire logic [ods_pkg::SRST_W-1:0]        soft_reset_i,
  input  wire logic                              dist_pwr_down_i,
  input  wire logic [NCH-1:0]                    exclude_i,
  input  wire logic [NCH-1:0]                    initial_level_high_i,
  input  wire logic [NCH*ods_pkg::OFFSET_W-1:0]  coarse_phase_offset_i,
  input  wire logic [NCH*ods_pkg::DIV_W-1:0]     high_cycles_i,
  input  wire logic [NCH*ods_pkg::DIV_W-1:0]     low_cycles_i,
  input  wire logic [NCH-1:0]                    cmos_mode_i,
  input  wire logic [NCH-1:0]                    out_pwr_down_i,
  input  wire logic [NCH-1:0]                    b_enable_i,
  input  wire logic [NCH*ods_pkg::POL_W-1:0]     cmos_polarity_i,
  input  wire logic [NCH-1:0]                    diff_invert_i,
  input  wire logic [NCH*ods_pkg::FRAC_W-1:0]    fine_frac_i,
  input  wire logic [NCH-1:0]                    delay_over_half_i,
  output logic                                   sync_active_o,
  output logic                                   soft_sync_o,
  output logic [NCH-1:0]                         frac_bad_o,
  output logic [NCH-1:0]                         diff_o,
  output logic [NCH-1:0]                         diff_en_o,
  output logic [NCH-1:0]                         a_o,
  output logic [NCH-1:0]                         a_en_o,
  output logic [NCH-1:0]                         b_o,
  output logic [NCH-1:0]                         b_en_o
);
  import ods_pkg::*;

  // Reset pin clears state at once, without waiting for a clock
  logic hard_rst;
  assign hard_rst = rst_i | ~chip_reset_n_i;

  logic sync_s1_ff, sync_s2_ff, sync_prev_ff;
  logic sleep_s1_ff, sleep_s2_ff;
  logic por_sync_ff;
  logic soft_sync_ff;
  logic hold_req, pin_rise, soft_rst_act;
  ods_state_e state_ff, nxt_state;
  logic [LAT_W-1:0] lat_ff;
  logic [LAT_W-1:0] lat_load;

  always_ff @(posedge clock_i or posedge hard_rst) begin
    if (hard_rst) begin
      sync_s1_ff   <= 1'b1;
      sync_s2_ff   <= 1'b1;
      sync_prev_ff <= 1'b1;
      sleep_s1_ff  <= 1'b1;
      sleep_s2_ff  <= 1'b1;
    end else begin
      sync_s1_ff   <= sync_n_i;
      sync_s2_ff   <= sync_s1_ff;
      sync_prev_ff <= sync_s2_ff;
      sleep_s1_ff  <= chip_sleep_n_i;
      sleep_s2_ff  <= sleep_s1_ff;
    end
  end

  assign pin_rise = sync_s2_ff & ~sync_prev_ff;

  // Held high for the first cycle after rst_i or reset pin release
  always_ff @(posedge clock_i or posedge hard_rst) begin
    if (hard_rst) begin
      por_sync_ff <= 1'b1;
    end else begin
      por_sync_ff <= 1'b0;
    end
  end

  assign soft_rst_act = (soft_reset_i == SRST_ALL);

  // Staged bit is ignored until the update strobe copies it
  always_ff @(posedge clock_i or posedge hard_rst) begin
    if (hard_rst) begin
      soft_sync_ff <= 1'b0;
    end else if (soft_rst_act) begin
      soft_sync_ff <= 1'b0;
    end else if (update_regs_i) begin
      soft_sync_ff <= soft_sync_stage_i;
    end
  end

  assign hold_req = ~sync_s2_ff | soft_sync_ff | soft_rst_act | dist_pwr_down_i
                  | ~sleep_s2_ff | vco_cal_busy_i | por_sync_ff;

  // Pin path already spent its synchronizer cycles; the extra cycle applies
  // when the VCO divider is bypassed, else its short cycle is absorbed
  assign lat_load = vco_div_used_i ? LAT_BASE : LAT_W'(LAT_BASE + LAT_EXTRA);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_HOLD:  if (!hold_req) nxt_state = ST_COUNT;
      ST_COUNT: begin
        if (hold_req) begin
          nxt_state = ST_HOLD;
        end else if (lat_ff == '0) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN:   if (hold_req) nxt_state = ST_HOLD;
      default:  nxt_state = ST_HOLD;
    endcase
  end

  always_ff @(posedge clock_i or posedge hard_rst) begin
    if (hard_rst) begin
      state_ff <= ST_HOLD;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clock_i or posedge hard_rst) begin
    if (hard_rst) begin
      lat_ff <= '0;
    end else if (state_ff == ST_HOLD) begin
      lat_ff <= lat_load;
    end else if (state_ff == ST_COUNT && lat_ff != '0) begin
      lat_ff <= lat_ff - 1'b1;
    end
  end

  logic running;
  assign running       = (state_ff == ST_RUN);
  assign sync_active_o = ~running;
  assign soft_sync_o   = soft_sync_ff;

  logic [NCH-1:0] lvl_ff;
  logic [DIV_W-1:0]    cnt_ff  [NCH];
  logic [OFFSET_W-1:0] wait_ff [NCH];
  logic awake;
  assign awake = sleep_s2_ff & ~dist_pwr_down_i;

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    logic [PHASE_W-1:0] phase;
    logic [DIV_W-1:0]   limit;
    logic [1:0]         pol;
    logic               stop;
    assign phase = ods_phase(initial_level_high_i[i], coarse_phase_offset_i[i*OFFSET_W +: OFFSET_W]);
    assign limit = lvl_ff[i] ? high_cycles_i[i*DIV_W +: DIV_W] : low_cycles_i[i*DIV_W +: DIV_W];
    assign stop  = delay_over_half_i[i] | frac_bad_o[i];
    assign pol   = ods_pol(cmos_polarity_i[i*POL_W +: POL_W]);

    // Preset sits static until release, so all held channels start together
    always_ff @(posedge clock_i or posedge hard_rst) begin
      if (hard_rst) begin
        lvl_ff[i]  <= 1'b0;
        cnt_ff[i]  <= '0;
        wait_ff[i] <= '0;
      end else if (!running && !exclude_i[i]) begin
        lvl_ff[i]  <= phase[PHASE_W-1];
        cnt_ff[i]  <= '0;
        wait_ff[i] <= phase[OFFSET_W-1:0];
      end else if (stop) begin
        lvl_ff[i]  <= lvl_ff[i];
      end else if (wait_ff[i] != '0) begin
        wait_ff[i] <= wait_ff[i] - 1'b1;
      end else if (cnt_ff[i] == limit) begin
        cnt_ff[i]  <= '0;
        lvl_ff[i]  <= ~lvl_ff[i];
      end else begin
        cnt_ff[i]  <= cnt_ff[i] + 1'b1;
      end
    end

    always_ff @(posedge clock_i or posedge hard_rst) begin
      if (hard_rst) begin
        frac_bad_o[i] <= 1'b0;
        diff_o[i]     <= 1'b0;
        a_o[i]        <= 1'b0;
        b_o[i]        <= 1'b0;
        diff_en_o[i]  <= 1'b0;
        a_en_o[i]     <= 1'b0;
        b_en_o[i]     <= 1'b0;
      end else begin
        frac_bad_o[i] <= fine_frac_i[i*FRAC_W +: FRAC_W] > FRAC_MAX;
        diff_o[i]     <= lvl_ff[i] ^ diff_invert_i[i];
        a_o[i]        <= lvl_ff[i] ^ pol[0];
        b_o[i]        <= lvl_ff[i] ^ pol[1];
        diff_en_o[i]  <= awake & ~cmos_mode_i[i] & ~out_pwr_down_i[i];
        a_en_o[i]     <= awake & cmos_mode_i[i] & ~out_pwr_down_i[i];
        b_en_o[i]     <= awake & cmos_mode_i[i] & ~out_pwr_down_i[i] & b_enable_i[i];
      end
    end
  end

  hold_enter_a: assert property (@(posedge clock_i) disable iff (hard_rst)
    (state_ff == ST_HOLD && !hold_req) |=> state_ff == ST_COUNT)
    else $error("hold did not start latency count");

  release_lat_a: assert property (@(posedge clock_i) disable iff (hard_rst)
    (state_ff == ST_COUNT && !hold_req && lat_ff == '0) |=> state_ff == ST_RUN)
    else $error("release not on latency end");

  count_len_a: assert property (@(posedge clock_i) disable iff (hard_rst)
    (state_ff == ST_HOLD ##1 state_ff == ST_COUNT) |-> lat_ff == $past(lat_load))
    else $error("latency count loaded wrong");

  sleep_hold_a: assert property (@(posedge clock_i) disable iff (hard_rst)
    !sleep_s2_ff |=> state_ff == ST_HOLD)
    else $error("sleep did not hold outputs");

  vco_hold_a: assert property (@(posedge clock_i) disable iff (hard_rst)
    vco_cal_busy_i |=> !running)
    else $error("vco calibration did not hold");

  soft_upd_a: assert property (@(posedge clock_i) disable iff (hard_rst)
    (!update_regs_i && !soft_rst_act) |=> soft_sync_ff == $past(soft_sync_ff))
    else $error("soft sync changed without update");

  preset_a: assert property (@(posedge clock_i) disable iff (hard_rst)
    (!running && !exclude_i[0]) |=> lvl_ff[0] == $past(initial_level_high_i[0]))
    else $error("held channel not at preset level");

  excl_run_a: assert property (@(posedge clock_i) disable iff (hard_rst)
    (exclude_i[0] && !g_ch[0].stop && wait_ff[0] == '0)
    |=> (cnt_ff[0] != $past(cnt_ff[0]) || lvl_ff[0] != $past(lvl_ff[0])))
    else $error("excluded channel stopped");

  stop_a: assert property (@(posedge clock_i) disable iff (hard_rst)
    (running && delay_over_half_i[0]) |=> $stable(lvl_ff[0]))
    else $error("over-long delay still toggles");

  frac_a: assert property (@(posedge clock_i) disable iff (hard_rst)
    fine_frac_i[FRAC_W-1:0] > FRAC_MAX |=> frac_bad_o[0])
    else $error("bad fraction not flagged");

  b_needs_a_a: assert property (@(posedge clock_i) disable iff (hard_rst)
    b_en_o[0] |-> a_en_o[0])
    else $error("B enabled without A");

  cmos_a_a: assert property (@(posedge clock_i) disable iff (hard_rst)
    (awake && cmos_mode_i[0] && !out_pwr_down_i[0]) |=> a_en_o[0] && !diff_en_o[0])
    else $error("CMOS A not enabled");

  dpd_hold_a: assert property (@(posedge clock_i) disable iff (hard_rst)
    dist_pwr_down_i |=> state_ff == ST_HOLD)
    else $error("distribution power-down did not hold");

  soft_hold_a: assert property (@(posedge clock_i) disable iff (hard_rst)
    soft_sync_ff |=> !running)
    else $error("soft sync did not hold");

  srst_hold_a: assert property (@(posedge clock_i) disable iff (hard_rst)
    soft_rst_act |=> state_ff == ST_HOLD && !soft_sync_ff)
    else $error("soft reset did not hold and clear");

  por_hold_a: assert property (@(posedge clock_i) disable iff (hard_rst)
    por_sync_ff |=> state_ff == ST_HOLD)
    else $error("power-up alignment skipped");

  pin_hold_a: assert property (@(posedge clock_i) disable iff (hard_rst)
    !sync_s2_ff |=> state_ff == ST_HOLD)
    else $error("sync pin low did not hold");

  sync_chain_a: assert property (@(posedge clock_i) disable iff (hard_rst)
    sync_s2_ff == $past(sync_s1_ff))
    else $error("sync pin skipped a stage");

  pair_pol_a: assert property (@(posedge clock_i) disable iff (hard_rst)
    !hard_rst |=> (a_o[0] ^ b_o[0]) == $past(g_ch[0].pol[0] ^ g_ch[0].pol[1]))
    else $error("pair outputs not from one level");

  diff_pol_a: assert property (@(posedge clock_i) disable iff (hard_rst)
    !hard_rst |=> diff_o[0] == ($past(lvl_ff[0]) ^ $past(diff_invert_i[0])))
    else $error("differential polarity wrong");

  diff_off_a: assert property (@(posedge clock_i) disable iff (hard_rst)
    (out_pwr_down_i[0] || cmos_mode_i[0]) |=> !diff_en_o[0])
    else $error("differential driver not off");

  pd_both_a: assert property (@(posedge clock_i) disable iff (hard_rst)
    out_pwr_down_i[0] |=> !a_en_o[0] && !b_en_o[0])
    else $error("power-down left a driver on");

  asleep_off_a: assert property (@(posedge clock_i) disable iff (hard_rst)
    !awake |=> !a_en_o[0] && !b_en_o[0] && !diff_en_o[0])
    else $error("driver on while asleep");

  wait_load_a: assert property (@(posedge clock_i) disable iff (hard_rst)
    (!running && !exclude_i[0]) |=> wait_ff[0] == $past(coarse_phase_offset_i[OFFSET_W-1:0]))
    else $error("phase offset preset wrong");

  pin_sync_c: cover property (@(posedge clock_i) disable iff (hard_rst)
    pin_rise ##1 state_ff == ST_COUNT);
  soft_sync_c: cover property (@(posedge clock_i) disable iff (hard_rst)
    soft_sync_ff ##[1:40] running);
  excl_c: cover property (@(posedge clock_i) disable iff (hard_rst)
    exclude_i[0] && !running && lvl_ff[0] != $past(lvl_ff[0]));
  stop_c: cover property (@(posedge clock_i) disable iff (hard_rst)
    running && delay_over_half_i[0] ##1 running);
  srst_c: cover property (@(posedge clock_i) disable iff (hard_rst)
    soft_rst_act ##[1:4] !running);

endmodule : ods_sync_ctrl
`default_nettype wire

// ### ods_pkg.sv
// Constants, types and helpers for the output divider sync controller
// Functional notes
// - Sync pin low then high starts alignment
// - Soft sync, soft reset, distribution power-down trigger alignment
// - Alignment runs automatically at power-up
// - Reset pin low then release aligns outputs
// - Sleep pin low then release aligns outputs
// - VCO calibration holds alignment until done
// - Release 14 to 15 cycles after pin rise, 15 to 16 with the VCO divider bypassed
// - Up to one cycle pin sampling uncertainty
// - Soft sync bit acts only on update
// - Held channels sit at preset, resume together
// - Excluded channels keep clocking through alignment
// - Alignment covers both pair outputs, CMOS too
// - Delay over half period stops output
// - CMOS mode turns output A on
// - One power-down for both; B only with A
// - Three-bit polarity field per output, shared by its two single-ended outputs
// - Differential polarity and power control per output
// - Power-on loads defaults then aligns
// - Reset pin restores defaults asynchronously
// - Soft reset needs both bits, no update
// - Coarse phase is 16 x start-high + offset
package ods_pkg;

  localparam int unsigned NUM_CH       = 4;
  localparam int unsigned OFFSET_W     = 4;
  localparam int unsigned PHASE_W      = OFFSET_W + 1;
  localparam int unsigned DIV_W        = 4;
  localparam int unsigned FRAC_W       = 6;
  localparam int unsigned POL_W        = 3;
  localparam int unsigned SRST_W       = 2;
  localparam int unsigned LAT_W        = 5;

  localparam logic [FRAC_W-1:0] FRAC_MAX    = 6'h2F;
  localparam logic [SRST_W-1:0] SRST_ALL    = 2'h3;
  localparam int unsigned       SYNC_LAT_MIN = 14;
  localparam int unsigned       SYNC_STAGES  = 2;
  localparam logic [LAT_W-1:0]  LAT_BASE     = LAT_W'(SYNC_LAT_MIN - SYNC_STAGES - 1);
  localparam logic [LAT_W-1:0]  LAT_EXTRA    = 5'h01;

  typedef enum logic [2:0] {
    ST_HOLD  = 3'h1,
    ST_COUNT = 3'h2,
    ST_RUN   = 3'h4
  } ods_state_e;

  // Coarse phase: start-high weighs 16, offset adds below it
  function automatic logic [PHASE_W-1:0] ods_phase(input logic start_hi, input logic [OFFSET_W-1:0] ofs);
    ods_phase = {start_hi, ofs};
  endfunction : ods_phase

  // Bit 2 flips both, bits 1:0 flip B and A on their own
  function automatic logic [1:0] ods_pol(input logic [POL_W-1:0] code);
    ods_pol = code[1:0] ^ {2{code[2]}};
  endfunction : ods_pol

endpackage : ods_pkg

// ### ods_pin_host.sv
// Host model that pulls the sync pin low for a set span
`timescale 1ns/1ps
`default_nettype none
module ods_pin_host #(
  parameter int LOW = 4
) (
  input  wire logic clock_i,
  input  wire logic go_i,
  output logic      sync_n_o
);
  int cnt = 0;
  initial sync_n_o = 1'b1;
  // Pin moves just after an edge, never on the sampled one
  always @(posedge clock_i) begin
    if (go_i) begin
      sync_n_o <= 1'b0;
      cnt      <= LOW;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else if (cnt == 1) begin
      sync_n_o <= 1'b1;
      cnt      <= 0;
    end
  end
endmodule : ods_pin_host
`default_nettype wire

// ### output_divider_sync_control_bench.sv
// Self-checking bench for the output divider sync controller
`timescale 1ns/1ps
`default_nettype none
module output_divider_sync_control_bench;
  import ods_pkg::*;
  localparam int N = NUM_CH;
  logic clock_i = 0, rst_i = 1, rn = 1, slp = 1, cal = 0, vdu = 1, ss = 0, upd = 0, dpd = 0, go = 0, sync_n;
  logic [1:0] srst = 0;
  logic [N-1:0] excl = 0, lvl_hi = 0, cm = 0, opd = 0, ben = 0, dinv = 0;
  logic [N-1:0] doh = 0, prev;
  logic [N*4-1:0] ofs = 0, hl = 0;
  logic [N*6-1:0] rf;
  logic [N*3-1:0] pol = 0;
  logic [N*6-1:0] frac = 0;
  logic act, ssync;
  logic [N-1:0] fbad, dif, den, a, aen, b, bo_en, ea, eb, ef;
  int failures = 0, n_checks = 0, n, t;
  always #25 clock_i = ~clock_i;
  ods_pin_host #(.LOW(5)) host_u (.clock_i(clock_i), .go_i(go), .sync_n_o(sync_n));
  ods_sync_ctrl dut_u (.clock_i(clock_i), .rst_i(rst_i), .chip_reset_n_i(rn), .sync_n_i(sync_n),
    .chip_sleep_n_i(slp), .vco_cal_busy_i(cal), .vco_div_used_i(vdu), .soft_sync_stage_i(ss),
    .update_regs_i(upd), .soft_reset_i(srst), .dist_pwr_down_i(dpd), .exclude_i(excl),
    .initial_level_high_i(lvl_hi), .coarse_phase_offset_i(ofs), .high_cycles_i(hl), .low_cycles_i(hl),
    .cmos_mode_i(cm), .out_pwr_down_i(opd), .b_enable_i(ben), .cmos_polarity_i(pol),
    .diff_invert_i(dinv), .fine_frac_i(frac), .delay_over_half_i(doh), .sync_active_o(act),
    .soft_sync_o(ssync), .frac_bad_o(fbad), .diff_o(dif), .diff_en_o(den), .a_o(a), .a_en_o(aen),
    .b_o(b), .b_en_o(bo_en));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge clock_i);
  endtask : cyc
  // Outputs are read mid-cycle, away from the edge that launches them
  task automatic settle(input int k);
    repeat (k) @(posedge clock_i);
    @(negedge clock_i);
  endtask : settle
  // Counts edges until the alignment lets go, bounded
  task automatic wait_rel(output int k);
    k = 0;
    do begin
      @(negedge clock_i);
      k++;
    end while (act !== 1'b0 && k < 40);
  endtask : wait_rel
  task automatic complete_run;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run
  initial begin
    #(50 * 6000);
    failures++;
    complete_run;
  end
  initial begin
    void'($urandom(32'hC2EC));
    cyc(2);
    rst_i <= 1'b0;
    wait_rel(n);
    chk(n > 11 && n < 20, 1, "power-up alignment");
    for (int v = 0; v < 2; v++) begin
      @(posedge clock_i) begin vdu <= v[0]; go <= 1'b1; end
      @(posedge clock_i) go <= 1'b0;
      settle(3);
      chk(act, 1, "held while pin low");
      @(posedge sync_n);
      wait_rel(n);
      // First negedge counted lies before the first edge that sees the pin high
      t = v ? 14 : 15;
      chk(n - 1 >= t && n - 1 <= t + 1, 1, "pin release latency");
    end
    // Soft sync acts only through the update strobe
    @(posedge clock_i) ss <= 1'b1;
    settle(6);
    chk({act, ssync}, 0, "staged bit ignored");
    @(posedge clock_i) upd <= 1'b1;
    @(posedge clock_i) begin upd <= 1'b0; ss <= 1'b0; end
    settle(3);
    chk({act, ssync}, 3, "soft sync applied");
    settle(20);
    chk(act, 1, "clear not yet applied");
    @(posedge clock_i) upd <= 1'b1;
    @(posedge clock_i) upd <= 1'b0;
    wait_rel(n);
    chk(n < 20 && ssync === 1'b0, 1, "soft sync release");
    for (int k = 0; k < 6; k++) begin
      @(posedge clock_i) case (k)
        0: srst <= 2'h1;
        1: srst <= 2'h3;
        2: dpd <= 1'b1;
        3: slp <= 1'b0;
        4: cal <= 1'b1;
        default: rn <= 1'b0;
      endcase
      settle(4);
      chk(act, k != 0, "trigger hold");
      if (k == 5)
        chk({aen, den, bo_en}, 0, "outputs cleared in reset");
      @(posedge clock_i) begin srst <= 0; dpd <= 0; slp <= 1; cal <= 0; rn <= 1; end
      wait_rel(n);
      chk(n < 20, 1, "trigger release");
    end
    // Channel 0 excluded, 1 and 3 at zero phase, 2 two cycles behind
    @(posedge clock_i) begin excl <= 4'h1; hl <= 16'h1111; ofs <= 16'h0200; lvl_hi <= 0; srst <= 2'h3; end
    settle(3);
    prev = dif;
    t = 0;
    for (int k = 0; k < 8; k++) begin
      @(negedge clock_i);
      chk(dif[3:1], 0, "held at preset");
      t += (dif[0] !== prev[0]);
      prev = dif;
    end
    chk(t > 2, 1, "excluded keeps clocking");
    @(posedge clock_i) srst <= 0;
    wait_rel(n);
    repeat (5) @(negedge clock_i);
    for (int k = 0; k < 8; k++) begin
      @(negedge clock_i);
      chk({dif[3], dif[2]}, {dif[1], ~dif[1]}, "aligned resume with offset");
    end
    // Over-long delay on channels 0 and 1 freezes them, channel 3 runs on
    @(posedge clock_i) doh <= 4'h3;
    settle(2);
    prev = dif;
    t = 0;
    for (int k = 0; k < 8; k++) begin
      @(negedge clock_i);
      chk(dif[1:0], prev[1:0], "over-long delay stops output");
      t += (dif[3] !== prev[3]);
      prev = dif;
    end
    chk(t > 2, 1, "unaffected channel keeps clocking");
    @(posedge clock_i) begin excl <= 0; doh <= 0; end
    for (int k = 0; k < 12; k++) begin
      // Host keeps random fractions in the supported range; k == 1 probes the flag
      for (int c = 0; c < N; c++)
        rf[6*c +: 6] = 6'($urandom % 48);
      @(posedge clock_i) begin
        lvl_hi <= N'($urandom); pol <= 12'($urandom); opd <= N'($urandom); ben <= N'($urandom);
        dinv <= N'($urandom); cm <= k[0] ? {N{1'b1}} : 0; srst <= 2'h3;
        frac <= k == 0 ? {N{6'h2F}} : k == 1 ? {N{6'h30}} : rf;
      end
      settle(3);
      for (int c = 0; c < N; c++) begin
        ea[c] = lvl_hi[c] ^ pol[3*c] ^ pol[3*c+2];
        eb[c] = lvl_hi[c] ^ pol[3*c+1] ^ pol[3*c+2];
        ef[c] = frac[6*c +: 6] > 6'h2F;
      end
      chk(fbad, ef, "fraction limit");
      if (k[0]) begin
        chk({aen, bo_en, den}, {~opd, ~opd & ben, 4'h0}, "single-ended enables");
        chk({a & aen, b & bo_en}, {ea & ~opd, eb & ~opd & ben}, "single-ended polarity");
      end else begin
        chk({den, aen, bo_en}, {~opd, 8'h00}, "differential enables");
        chk(dif & den, (lvl_hi ^ dinv) & ~opd, "differential polarity");
      end
    end
    complete_run;
  end
endmodule : output_divider_sync_control_bench
`default_nettype wire
